// ### sim/cli_cpu.sv
`timescale 1ns/1ps
// CPU side: takes an offer promptly or after a random stall.
module cli_cpu(input wire mclk,input wire irq_valid,output logic ack_take);
initial ack_take = 1'h0;
always @(negedge mclk) ack_take <= irq_valid&&($urandom%3==0);
endmodule

// ### sim/cli_props.sv
`timescale 1ns/1ps
// Offer outputs are combinational, so they are judged in the same cycle.
module cli_props(input wire mclk,input wire rst,input wire [15:0] irq_req,
    input wire global_mask_bit,input wire reg_wr,input wire reg_sel,
    input wire [15:0] reg_wdata,input wire ack_take,input wire swi_valid,
    input wire swi_trap,input wire [3:0] swi_idx,input wire irq_valid,
    input wire [3:0] irq_idx,input wire [15:0] interrupt_flag_register,
    input wire [15:0] level_enable_register);
default clocking @(posedge mclk); endclocking
default disable iff (rst);
wire [15:0] f = interrupt_flag_register;
wire [15:0] e = level_enable_register;
property p_clr; reg_wr&&!reg_sel |=>
    (f&~($past(reg_wdata)|$past(irq_req)))==16'h0000; endproperty
a_clr: assert property(p_clr) else $error("flag kept");
property p_off; irq_valid |-> e[irq_idx]&&f[irq_idx]&&!global_mask_bit;
endproperty
a_off: assert property(p_off) else $error("bad offer");
property p_on; (|(f&e))&&!global_mask_bit |-> irq_valid; endproperty
a_on: assert property(p_on) else $error("no offer");
property p_pri; irq_valid |->
    (f&e&((16'h0001<<irq_idx)-16'h0001))==16'h0000; endproperty
a_pri: assert property(p_pri) else $error("order");
property p_ack; ack_take&&irq_valid |=> !e[$past(irq_idx)]; endproperty
a_ack: assert property(p_ack) else $error("ack enable");
property p_swi; swi_valid&&!swi_trap |=> !e[$past(swi_idx)]; endproperty
a_swi: assert property(p_swi) else $error("swi enable");
property p_wen; reg_wr&&reg_sel&&!ack_take&&!swi_valid |=>
    e==$past(reg_wdata); endproperty
a_wen: assert property(p_wen) else $error("enable write");
property p_rst; $fell(rst) |-> e==16'h0000&&f==16'h0000; endproperty
a_rst: assert property(p_rst) else $error("reset value");
c_ack: cover property(ack_take&&irq_valid);
c_trap: cover property(swi_valid&&swi_trap);
c_mask: cover property(global_mask_bit&&(|(f&e)));
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
logic mclk=0,rst=1,gm=0,wr=0,sel=0,sv=0,st=0,ack,v,iv;
logic [15:0] rq=0,wd=0,rd,fr,er,mf,me,mr,t,u;
logic [3:0] si=0,x,ix;
int err_count=0,total_checks=0,cyc=0;
always #25 mclk = ~mclk;
cli_core dut_u(.mclk,.rst,.irq_req(rq),.global_mask_bit(gm),.reg_wr(wr),
    .reg_sel(sel),.reg_wdata(wd),.reg_rdata(rd),.ack_take(ack),
    .swi_valid(sv),.swi_trap(st),.swi_idx(si),.irq_valid(iv),.irq_idx(ix),
    .interrupt_flag_register(fr),.level_enable_register(er));
cli_cpu cpu_u(.mclk,.irq_valid(iv),.ack_take(ack));
// Reference offer: lowest enabled pending bit while unmasked.
always @* begin
    v=0; x=0;
    for (int i=15; i>=0; i--) if (mf[i]&me[i]&!gm) begin v=1; x=4'(i); end
end
// Reference registers; a request set beats a write or acknowledge clear in the same cycle, but reset wins.
always @(posedge mclk) begin
    u = wr&&sel ? wd : me;
    t = wr&&!sel ? mf&wd : mf;
    if (ack&&v) begin t[x]=0; u[x]=0; end
    if (sv&&!st) u[si]=0;
    mr <= rst ? 16'h0000 : (sel ? me : mf);
    mf <= rst ? 16'h0000 : t|rq;
    me <= rst ? 16'h0000 : u;
end
task chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (e!==s) begin err_count++; $display("BAD %s exp %h got %h",n,e,s); end
endtask
task end_of_test;
    $display("checks %0d mismatches %0d",total_checks,err_count);
    if (err_count==0&&total_checks>0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask
// A hang is cut off well past the expected run length.
always @(posedge mclk) if (++cyc==3000) begin err_count++; end_of_test; end
initial begin
    void'($urandom(42521));
    repeat (2) @(negedge mclk);
    rst=0;
    chk("reset", 16'h0000, er|fr);
    $display("reset test done");
    // Random traffic, with rare resets in mid-run to hit the reset path.
    repeat (2000) begin
        @(negedge mclk);
        chk("flags", mf, fr);
        chk("enables", me, er);
        chk("offer", {v,x}, {iv,ix});
        chk("read", mr, rd);
        rst = $urandom%400==0;
        rq = 16'($urandom)&16'($urandom)&16'($urandom);
        gm = $urandom%4==0;
        wr = $urandom%3==0;
        sel = 1'($urandom);
        wd = 16'($urandom); // An OS is assumed, so bit 15 is written.
        sv = $urandom%6==0;
        st = 1'($urandom);
        si = 4'($urandom);
    end
    $display("random test done");
    end_of_test;
end
endmodule
bind cli_core cli_props chk_u(.mclk,.rst,.irq_req,.global_mask_bit,.reg_wr,
    .reg_sel,.reg_wdata,.ack_take,.swi_valid,.swi_trap,.swi_idx,.irq_valid,
    .irq_idx,.interrupt_flag_register,.level_enable_register);

// ### verilog/cli_core.v
`timescale 1ns/1ps
`include "cli_map.vh"
module cli_core (
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Incoming requests, one pulse or level per source.
    input wire [15:0] irq_req,
    // Global mask bit from the CPU status.
    input wire global_mask_bit,
    // Register access port: select 0 is flags, 1 is enables.
    input wire reg_wr,
    input wire reg_sel,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // Service: CPU takes the offered level.
    input wire ack_take,
    // Software interrupt instruction and trap instruction.
    input wire swi_valid,
    input wire swi_trap,
    input wire [3:0] swi_idx,
    // Offered interrupt to the pipeline.
    output wire irq_valid,
    output wire [3:0] irq_idx,
    // Register views.
    output wire [15:0] interrupt_flag_register,
    output wire [15:0] level_enable_register
);
    reg [15:0] flag_reg;
    reg [15:0] flag_next;
    reg [15:0] en_reg;
    reg [15:0] en_next;
    wire [15:0] ack_mask;
    wire [15:0] swi_mask;
    wire [15:0] cand;
    wire ack_fire;

    assign interrupt_flag_register = flag_reg;
    assign level_enable_register = en_reg;

    // Only enabled, pending levels compete, and only with the mask clear.
    // The nonmaskable and reset paths never pass through here.
    assign cand = global_mask_bit ? 16'h0000
        : (flag_reg & en_reg);

    cli_prio_enc u_prio (
        .req(cand),
        .any(irq_valid),
        .idx(irq_idx)
    );

    assign ack_fire = ack_take && irq_valid;

    cli_onehot u_ack (
        .idx(irq_idx),
        .en(ack_fire),
        .mask(ack_mask)
    );

    // A trap leaves the enable alone, so it is excluded here.
    cli_onehot u_swi (
        .idx(swi_idx),
        .en(swi_valid && !swi_trap),
        .mask(swi_mask)
    );

    // Flags: a write of 0 clears, acknowledge clears, new requests set.
    // Arrival is applied last so a request in the clearing cycle survives.
    always @* begin
        flag_next = flag_reg;
        if (reg_wr && reg_sel == `CLI_SEL_FLAGS) begin
            flag_next = flag_next & reg_wdata;
        end
        flag_next = flag_next & ~ack_mask;
        flag_next = flag_next | irq_req;
    end

    // Enables: software write, then automatic clear on service.
    // Bit 15 is stored like any other; keeping it is software's duty.
    always @* begin
        en_next = en_reg;
        if (reg_wr && reg_sel == `CLI_SEL_ENABLES) begin
            en_next = reg_wdata;
        end
        en_next = en_next & ~ack_mask & ~swi_mask;
    end

    // State registers.
    always @(posedge mclk) begin
        if (rst) begin
            flag_reg <= `CLI_FLAG_RESET;
            en_reg <= `CLI_ENABLE_RESET;
        end else begin
            flag_reg <= flag_next;
            en_reg <= en_next;
        end
    end

    // Registered read data follows the selected register.
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_sel == `CLI_SEL_ENABLES) begin
            reg_rdata <= en_reg;
        end else begin
            reg_rdata <= flag_reg;
        end
    end
endmodule

// ### verilog/cli_map.vh
// How it works
// - A written 0 clears a set flag and its request; a 1 never clears.
// - A flag reads 1 while pending; bit 14 is datalog, 13..0 levels 14..1.
// - A 16-bit enable register has one bit per maskable level.
// - The enables do not touch the nonmaskable or external reset paths.
// - The enables are read/write; 1 enables a level and 0 disables it.
// - A level with enable 0 is never acknowledged, whatever the mask bit.
// - An enabled level is acknowledged when flagged and the mask bit is 0.
// - Service or a software interrupt instruction clears that enable bit.
// - A trap-requested interrupt leaves its enable bit unchanged.
// - Reset clears every enable bit to 0.
// - Enable bit 15 gates RTOS, 14 datalog, and 13..0 levels 14..1.
// - Flag bit 15 records pending RTOS interrupts and clears on a 0 write.
// - A flag clears when its level is acknowledged, and all clear on reset.
// - An arriving request sets its pending flag.
`ifndef CLI_MAP_VH
`define CLI_MAP_VH
`define CLI_WIDTH 16
`define CLI_IDX_W 4
`define CLI_FLAG_RESET 16'h0000
`define CLI_ENABLE_RESET 16'h0000
`define CLI_BIT_RTOS 4'hF
`define CLI_BIT_DLOG 4'hE
`define CLI_SEL_FLAGS 1'h0
`define CLI_SEL_ENABLES 1'h1
`endif

// ### verilog/cli_onehot.v
`timescale 1ns/1ps
`include "cli_map.vh"
module cli_onehot (
    // Index and qualifier.
    input wire [3:0] idx,
    input wire en,
    // One-hot mask.
    output wire [15:0] mask
);
    genvar g;

    // One decode term per bit.
    generate
        for (g = 0; g < `CLI_WIDTH; g = g + 1) begin : dec
            assign mask[g] = en && (idx == g);
        end
    endgenerate
endmodule

// ### verilog/cli_prio_enc.v
`timescale 1ns/1ps
`include "cli_map.vh"
module cli_prio_enc (
    // Candidate vector.
    input wire [15:0] req,
    // Winner.
    output reg any,
    output reg [3:0] idx
);
    integer i;

    // Scan downward so the lowest set bit is the last to be taken.
    always @* begin
        any = 1'h0;
        idx = 4'h0;
        for (i = `CLI_WIDTH - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                any = 1'h1;
                idx = i[3:0];
            end
        end
    end
endmodule
